// ### src/fault_resp_params.svh
// Offsets, field positions, reset values and timing for the fault response block
// Functional notes
// - Enable bit set: low-bus UV uses fault_response_ctrl_six[7:6]
// - Enable bit clear: mode pin code instead
// - Low-bus UV sets status bit 3, alert
// - High-bus OV sets status bit 4, alert
// - Code 00 flags only, switching continues
// - Code 11 behaves exactly like 00
// - Code 01 stops, restarts 500ms after clear
// - Code 10 stops until enable toggle
// - high_bus_fault_response_ctrl byte wide, read/write, resets 00h
// - Enable bit set: high-bus OV uses high_bus_fault_response_ctrl[1:0]
`ifndef FAULT_RESP_PARAMS_SVH
`define FAULT_RESP_PARAMS_SVH

`define OFS_RESP_CTRL_SIX 8'hB7
`define OFS_HIGH_BUS_RESP 8'hB8
`define OFS_FAULT_STATUS 8'hD7

`define RST_RESP_CTRL_SIX 8'h00
`define RST_HIGH_BUS_RESP 8'h00
`define RST_FAULT_STATUS 8'h00

`define FLD_LOW_IN_UV_HI 7
`define FLD_LOW_IN_UV_LO 6
`define FLD_HIGH_OUT_OV_HI 1
`define FLD_HIGH_OUT_OV_LO 0

`define STS_LOW_IN_UV 3
`define STS_HIGH_OUT_OV 4

`define CODE_FLAG 2'h0
`define CODE_HICCUP 2'h1
`define CODE_LATCH 2'h2
`define CODE_FLAG_ALT 2'h3

`define HICCUP_DELAY_MS 500
`define CLK_FREQ_KHZ 100000
`define HICCUP_CYCLES (`HICCUP_DELAY_MS * `CLK_FREQ_KHZ)

`endif

// ### src/fault_resp_pkg.sv
// Types shared by the fault response block
package fault_resp_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic ack;
    logic nak;
    logic [7:0] rdata;
  } reg_rsp_s;

  typedef enum logic [1:0] {
    RESP_FLAG,
    RESP_HICCUP,
    RESP_LATCH
  } resp_action_e;

  typedef enum logic [1:0] {
    CH_RUN,
    CH_HICCUP_FAULT,
    CH_HICCUP_WAIT,
    CH_LATCHED
  } chan_state_e;

endpackage

// ### src/enable_toggle_detect.sv
// Detects a re-enable of either the switching enable or the main enable
`timescale 1ns/1ps
module enable_toggle_detect (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Enables
  input wire logic pwm_en_i,
  input wire logic main_en_i,
  // Pulse on a low-to-high toggle of either enable
  output logic toggle_o
);

  logic pwm_en_q;
  logic main_en_q;

  // Start high so that enables already high at reset release are not a toggle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_en_q <= 1'b1;
      main_en_q <= 1'b1;
    end else begin
      pwm_en_q <= pwm_en_i;
      main_en_q <= main_en_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      toggle_o <= 1'b0;
    end else begin
      toggle_o <= (pwm_en_i & ~pwm_en_q) | (main_en_i & ~main_en_q);
    end
  end

endmodule

// ### src/fault_channel.sv
// Per-fault reaction sequencer: flag, hiccup with auto restart, or latch-off
`timescale 1ns/1ps
`include "fault_resp_params.svh"
module fault_channel
  import fault_resp_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = `HICCUP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Fault condition and chosen reaction
  input wire logic fault_i,
  input wire resp_action_e action_i,
  input wire logic toggle_i,
  // Switching must stop while high
  output logic halt_o
);

  localparam int unsigned CW = $clog2(HICCUP_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HICCUP_CYCLES - 1);

  chan_state_e state;
  chan_state_e next_state;
  logic [CW-1:0] cnt;

  always_comb begin
    next_state = state;
    case (state)
      CH_RUN: begin
        if (fault_i && action_i == RESP_HICCUP) begin
          next_state = CH_HICCUP_FAULT;
        end else if (fault_i && action_i == RESP_LATCH) begin
          next_state = CH_LATCHED;
        end
      end
      CH_HICCUP_FAULT: begin
        if (!fault_i) begin
          next_state = CH_HICCUP_WAIT;
        end
      end
      CH_HICCUP_WAIT: begin
        if (fault_i) begin
          next_state = CH_HICCUP_FAULT;
        end else if (cnt == LAST) begin
          next_state = CH_RUN;
        end
      end
      CH_LATCHED: begin
        // Toggle ignored while a stopping fault persists: no one-cycle restart slips out
        if (toggle_i && !(fault_i && action_i != RESP_FLAG)) begin
          next_state = CH_RUN;
        end
      end
      default: next_state = CH_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= CH_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
    end else if (state == CH_HICCUP_WAIT && !fault_i) begin
      cnt <= cnt + CW'(1);
    end else begin
      cnt <= '0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_o <= 1'b0;
    end else begin
      halt_o <= (next_state != CH_RUN);
    end
  end

endmodule

// ### src/bus_fault_response_select.sv
// Fault response selection, status flagging and switching gate for two bus faults
`timescale 1ns/1ps
`include "fault_resp_params.svh"
module bus_fault_response_select
  import fault_resp_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = `HICCUP_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port from the management serial bus engine
  input wire reg_req_s reg_req_i,
  output reg_rsp_s reg_rsp_o,
  // Fault selection controls
  input wire logic indiv_resp_en_i,
  input wire logic [1:0] mode_code_i,
  // Fault conditions, high while present
  input wire logic low_voltage_bus_in_uv_i,
  input wire logic high_voltage_bus_out_ov_i,
  // Enables
  input wire logic pwm_en_i,
  input wire logic main_en_i,
  // Outputs
  output logic switch_en_o,
  output logic fault_alert_n_o,
  output logic [7:0] fault_status_o
);

  logic [7:0] fault_response_ctrl_six;
  logic [7:0] high_bus_fault_response_ctrl;
  logic [7:0] fault_status;
  logic [7:0] status_set;
  logic [7:0] status_clr;
  logic toggle;
  logic halt_uv;
  logic halt_ov;
  resp_action_e uv_action;
  resp_action_e ov_action;
  logic hit_six;
  logic hit_high;
  logic hit_status;

  // Codes 00 and 11 both flag only
  function automatic resp_action_e decode_code(input logic [1:0] code);
    resp_action_e a;
    a = RESP_FLAG;
    if (code == `CODE_HICCUP) begin
      a = RESP_HICCUP;
    end else if (code == `CODE_LATCH) begin
      a = RESP_LATCH;
    end else begin
      a = RESP_FLAG;
    end
    return a;
  endfunction

  // Per-fault field when enabled, mode pin code otherwise
  function automatic resp_action_e pick_action(input logic en, input logic [1:0] field,
                                               input logic [1:0] pin);
    resp_action_e a;
    a = en ? decode_code(field) : decode_code(pin);
    return a;
  endfunction

  assign hit_six = (reg_req_i.addr == `OFS_RESP_CTRL_SIX);
  assign hit_high = (reg_req_i.addr == `OFS_HIGH_BUS_RESP);
  assign hit_status = (reg_req_i.addr == `OFS_FAULT_STATUS);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_response_ctrl_six <= `RST_RESP_CTRL_SIX;
    end else if (reg_req_i.wr && hit_six) begin
      fault_response_ctrl_six <= reg_req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_bus_fault_response_ctrl <= `RST_HIGH_BUS_RESP;
    end else if (reg_req_i.wr && hit_high) begin
      high_bus_fault_response_ctrl <= reg_req_i.wdata;
    end
  end

  assign uv_action = pick_action(indiv_resp_en_i,
    fault_response_ctrl_six[`FLD_LOW_IN_UV_HI:`FLD_LOW_IN_UV_LO], mode_code_i);
  assign ov_action = pick_action(indiv_resp_en_i,
    high_bus_fault_response_ctrl[`FLD_HIGH_OUT_OV_HI:`FLD_HIGH_OUT_OV_LO],
    mode_code_i);

  // Status bits are flagged whatever the reaction; a fault that persists re-sets them
  always_comb begin
    status_set = 8'h00;
    status_set[`STS_LOW_IN_UV] = low_voltage_bus_in_uv_i;
    status_set[`STS_HIGH_OUT_OV] = high_voltage_bus_out_ov_i;
  end

  // Write one to clear; only the two bits this block owns are clearable
  always_comb begin
    status_clr = 8'h00;
    if (reg_req_i.wr && hit_status) begin
      status_clr[`STS_LOW_IN_UV] = reg_req_i.wdata[`STS_LOW_IN_UV];
      status_clr[`STS_HIGH_OUT_OV] = reg_req_i.wdata[`STS_HIGH_OUT_OV];
    end
  end

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_status <= `RST_FAULT_STATUS;
    end else begin
      fault_status <= (fault_status & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_status_o <= `RST_FAULT_STATUS;
    end else begin
      fault_status_o <= (fault_status & ~status_clr) | status_set;
    end
  end

  // Alert follows the next status value so it falls in the same cycle as the flag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_alert_n_o <= 1'b1;
    end else begin
      fault_alert_n_o <= ~(|((fault_status & ~status_clr) | status_set));
    end
  end

  enable_toggle_detect u_toggle (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pwm_en_i(pwm_en_i),
    .main_en_i(main_en_i),
    .toggle_o(toggle)
  );

  fault_channel #(
    .HICCUP_CYCLES(HICCUP_CYCLES)
  ) u_uv_chan (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .fault_i(low_voltage_bus_in_uv_i),
    .action_i(uv_action),
    .toggle_i(toggle),
    .halt_o(halt_uv)
  );

  fault_channel #(
    .HICCUP_CYCLES(HICCUP_CYCLES)
  ) u_ov_chan (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .fault_i(high_voltage_bus_out_ov_i),
    .action_i(ov_action),
    .toggle_i(toggle),
    .halt_o(halt_ov)
  );

  // Flag-only faults never reach the halt terms, so switching carries on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      switch_en_o <= 1'b0;
    end else begin
      switch_en_o <= pwm_en_i & main_en_i & ~halt_uv & ~halt_ov;
    end
  end

  // One-cycle answer; unmapped addresses answer with nak and zero data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rsp_o <= '0;
    end else begin
      reg_rsp_o.ack <= 1'b0;
      reg_rsp_o.nak <= 1'b0;
      reg_rsp_o.rdata <= 8'h00;
      if (reg_req_i.wr || reg_req_i.rd) begin
        if (hit_six) begin
          reg_rsp_o.ack <= 1'b1;
          reg_rsp_o.rdata <= reg_req_i.rd ? fault_response_ctrl_six : 8'h00;
        end else if (hit_high) begin
          reg_rsp_o.ack <= 1'b1;
          reg_rsp_o.rdata <= reg_req_i.rd ? high_bus_fault_response_ctrl : 8'h00;
        end else if (hit_status) begin
          reg_rsp_o.ack <= 1'b1;
          reg_rsp_o.rdata <= reg_req_i.rd ? fault_status : 8'h00;
        end else begin
          reg_rsp_o.nak <= 1'b1;
        end
      end
    end
  end

endmodule

// ### tb/ctrl_model.sv
// System controller model: register strobes and the two enable pins
`timescale 1ns/1ps
module ctrl_model
  import fault_resp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Register port
  output reg_req_s req_o,
  input wire reg_rsp_s rsp_i,
  // Enables
  output logic pwm_en_o,
  output logic main_en_o
);
  initial begin
    req_o = '0;
    pwm_en_o = 1'b1;
    main_en_o = 1'b1;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output reg_rsp_s r);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    // Released lines show garbage, not the last value
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 r = rsp_i;
  endtask
  // Pulse one enable low for a cycle to resume after a latch-off
  task automatic toggle(input logic main);
    @(posedge clk_i);
    main_en_o <= !main;
    pwm_en_o <= main;
    @(posedge clk_i);
    main_en_o <= 1'b1;
    pwm_en_o <= 1'b1;
  endtask
endmodule

// ### tb/bus_fault_response_select_asserts.sv
// Port-level checks for the fault response block
`timescale 1ns/1ps
module bus_fault_response_select_asserts
  import fault_resp_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = 20
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire reg_req_s reg_req_i,
  input wire reg_rsp_s reg_rsp_o,
  input wire logic indiv_resp_en_i,
  input wire logic [1:0] mode_code_i,
  input wire logic low_voltage_bus_in_uv_i,
  input wire logic high_voltage_bus_out_ov_i,
  input wire logic pwm_en_i,
  input wire logic main_en_i,
  input wire logic switch_en_o,
  input wire logic fault_alert_n_o,
  input wire logic [7:0] fault_status_o
);
  localparam int RLOW = HICCUP_CYCLES + 1;
  wire uv = low_voltage_bus_in_uv_i;
  wire ov = high_voltage_bus_out_ov_i;
  wire req = reg_req_i.wr || reg_req_i.rd;
  wire hit = reg_req_i.addr inside {8'hB7, 8'hB8, 8'hD7};
  wire pin_latch = !indiv_resp_en_i && mode_code_i == 2'h2;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_UV_FLAG: assert property ($rose(uv) |=> fault_status_o[3] && !fault_alert_n_o)
    else $error("uv not flagged");
  AST_OV_FLAG: assert property ($rose(ov) |=> fault_status_o[4] && !fault_alert_n_o)
    else $error("ov not flagged");
  AST_ACK: assert property (req && hit |=> reg_rsp_o.ack && !reg_rsp_o.nak)
    else $error("mapped access not acked");
  AST_NAK: assert property (req && !hit |=> reg_rsp_o.nak && reg_rsp_o.rdata == 8'h00)
    else $error("unmapped access not refused");
  AST_FLAG_RUN: assert property (
    (!indiv_resp_en_i && mode_code_i == 2'h3 && pwm_en_i && main_en_i)[*3] |-> switch_en_o)
    else $error("flag-only code stopped switching");
  AST_LATCH_STOP: assert property (pin_latch && $rose(uv) |-> ##2 !switch_en_o)
    else $error("latch code did not stop");
  AST_LATCH_HOLD: assert property ($fell(switch_en_o) && pin_latch ##1
    (!$rose(pwm_en_i) && !$rose(main_en_i))[*5] |=> !switch_en_o)
    else $error("latch released without toggle");
  AST_HICCUP: assert property (!indiv_resp_en_i && mode_code_i == 2'h1 && $fell(ov) |->
    ##RLOW !switch_en_o ##1 switch_en_o)
    else $error("hiccup restart timing");
endmodule

// ### tb/tb_bus_fault_response_select.sv
// Self-checking bench for the bus fault response block
`timescale 1ns/1ps
`include "fault_resp_params.svh"
module tb_bus_fault_response_select;
  import fault_resp_pkg::*;
  // Short hiccup delay keeps the run brief
  localparam int unsigned HC = 20;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ind = 1'b0;
  logic [1:0] mode = 2'h0;
  logic uv = 1'b0;
  logic ov = 1'b0;
  logic pwm;
  logic men;
  logic sw;
  logic al_n;
  logic [7:0] sts;
  reg_req_s req;
  reg_rsp_s rsp;
  int failures = 0;
  int tests_run = 0;
  always #5 clk_i = ~clk_i;
  ctrl_model u_ctrl (.clk_i(clk_i), .req_o(req), .rsp_i(rsp), .pwm_en_o(pwm), .main_en_o(men));
  bus_fault_response_select #(.HICCUP_CYCLES(HC)) DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(req), .reg_rsp_o(rsp),
    .indiv_resp_en_i(ind), .mode_code_i(mode),
    .low_voltage_bus_in_uv_i(uv), .high_voltage_bus_out_ov_i(ov),
    .pwm_en_i(pwm), .main_en_i(men),
    .switch_en_o(sw), .fault_alert_n_o(al_n), .fault_status_o(sts)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] an, input logic [7:0] exp);
    reg_rsp_s r;
    u_ctrl.xfer(w, a, d, r);
    check({6'h00, r.ack, r.nak}, {6'h00, an});
    check(r.rdata, exp);
  endtask
  task automatic swchk(input logic e);
    #1 check({7'h00, sw}, {7'h00, e});
  endtask
  // Hold one fault three cycles, then check flag, alert and gate
  task automatic fault(input logic [1:0] md, input logic which, input logic stop);
    @(posedge clk_i);
    mode <= md;
    ov <= which;
    uv <= !which;
    cyc(3);
    #1 check(sts, which ? 8'h10 : 8'h08);
    check({7'h00, al_n}, 8'h00);
    swchk(!stop);
    @(posedge clk_i);
    ov <= 1'b0;
    uv <= 1'b0;
  endtask
  task automatic clr();
    acc(1'b1, `OFS_FAULT_STATUS, 8'h18, 2'h2, 8'h00);
    cyc(1);
    #1 check(sts, 8'h00);
    check({7'h00, al_n}, 8'h01);
  endtask
  initial begin
    cyc(4);
    arst_n_i <= 1'b1;
    acc(1'b0, `OFS_RESP_CTRL_SIX, 8'h00, 2'h2, `RST_RESP_CTRL_SIX);
    acc(1'b0, `OFS_HIGH_BUS_RESP, 8'h00, 2'h2, `RST_HIGH_BUS_RESP);
    acc(1'b1, `OFS_HIGH_BUS_RESP, 8'hA5, 2'h2, 8'h00);
    acc(1'b0, `OFS_HIGH_BUS_RESP, 8'h00, 2'h2, 8'hA5);
    acc(1'b1, 8'h10, 8'h5A, 2'h1, 8'h00);
    acc(1'b0, 8'h10, 8'h00, 2'h1, 8'h00);
    // Fields ask to stop, yet the mode pin rules while individual control is off
    acc(1'b1, `OFS_HIGH_BUS_RESP, 8'h02, 2'h2, 8'h00);
    acc(1'b1, `OFS_RESP_CTRL_SIX, 8'h80, 2'h2, 8'h00);
    for (int m = 0; m < 4; m++) begin
      fault(2'(m), m[0], m == 1 || m == 2);
      if (m == 1) begin
        cyc(HC / 2);
        swchk(1'b0);
        cyc(HC);
        swchk(1'b1);
      end else if (m == 2) begin
        cyc(8);
        swchk(1'b0);
        u_ctrl.toggle(1'b0);
        cyc(5);
        swchk(1'b1);
      end else begin
        cyc(2);
        swchk(1'b1);
      end
      clr();
    end
    @(posedge clk_i);
    ind <= 1'b1;
    fault(2'h3, 1'b0, 1'b1);
    cyc(8);
    swchk(1'b0);
    u_ctrl.toggle(1'b1);
    cyc(5);
    swchk(1'b1);
    clr();
    acc(1'b1, `OFS_HIGH_BUS_RESP, 8'h01, 2'h2, 8'h00);
    fault(2'h3, 1'b1, 1'b1);
    cyc(10);
    ov <= 1'b1;
    cyc(2);
    ov <= 1'b0;
    cyc(15);
    swchk(1'b0);
    cyc(10);
    swchk(1'b1);
    // Mid-run reset clears the sticky status and the written field
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    cyc(2);
    #1 check(sts, `RST_FAULT_STATUS);
    check({7'h00, al_n}, 8'h01);
    swchk(1'b0);
    cyc(1);
    arst_n_i <= 1'b1;
    acc(1'b0, `OFS_HIGH_BUS_RESP, 8'h00, 2'h2, `RST_HIGH_BUS_RESP);
    swchk(1'b1);
    conclude();
  end
  initial begin
    cyc(20000);
    failures++;
    conclude();
  end
endmodule
bind bus_fault_response_select bus_fault_response_select_asserts #(
  .HICCUP_CYCLES(HICCUP_CYCLES)
) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .reg_rsp_o(reg_rsp_o),
  .indiv_resp_en_i(indiv_resp_en_i), .mode_code_i(mode_code_i),
  .low_voltage_bus_in_uv_i(low_voltage_bus_in_uv_i),
  .high_voltage_bus_out_ov_i(high_voltage_bus_out_ov_i),
  .pwm_en_i(pwm_en_i), .main_en_i(main_en_i), .switch_en_o(switch_en_o),
  .fault_alert_n_o(fault_alert_n_o), .fault_status_o(fault_status_o)
);
